// ==== verilog/eim_top.sv ====
// Ethernet interrupt flags, MII management data and low station address
// registers behind an AXI4-Lite slave, with the serial management engine.
// Assumes event strobes come from MAC logic on mclk_in, the factory address
// is a static value, and the management data pin is synchronised here.
//
// Summary of operation
// - Receive-complete flag, bit 7, sets on each error-free received frame.
// - Frame-waiting flag, bit 6, reflects nonzero pending count; direct writes ignored.
// - Receive-activity flag, bit 5, sets whenever frame data enters receive FIFO.
// - Transmit-complete flag, bit 3, sets when frame done and status written.
// - Transmit-aborted flag, bit 2, sets when the MAC abandons a frame.
// - Descriptor-missing flag, bit 1, sets on receive descriptor overrun.
// - Receive FIFO overrun flag, bit 0, sets on receive FIFO overflow.
// - Other flags clear only by reset, a plain write of zero, or writing one through clear or invert alias.
// - Writing management write data while idle starts a write cycle with held addresses.
// - Completed management read places PHY data in the read-data register.
// - Data and station registers take 32-bit and low 16-bit accesses; upper 16-bit and 8-bit ones ignored.
// - Upper sixteen bits of data and station registers read as zero.
// - Station register holds octet six in bits 15-8, five in 7-0.
// - Reset loads the station register from the factory address.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "eim_regs.svh"

module eim_top
  import eim_pkg::*;
(
  input  wire logic        mclk_in,          // System clock, 100 MHz
  input  wire logic        rstn_in,          // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr_in,  // Write address
  input  wire logic        s_axi_awvalid_in, // Write address valid
  output logic             s_axi_awready_out,// Write address ready
  input  wire logic [31:0] s_axi_wdata_in,   // Write data
  input  wire logic [3:0]  s_axi_wstrb_in,   // Write byte strobes
  input  wire logic        s_axi_wvalid_in,  // Write data valid
  output logic             s_axi_wready_out, // Write data ready
  output logic [1:0]       s_axi_bresp_out,  // Write response
  output logic             s_axi_bvalid_out, // Write response valid
  input  wire logic        s_axi_bready_in,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr_in,  // Read address
  input  wire logic        s_axi_arvalid_in, // Read address valid
  output logic             s_axi_arready_out,// Read address ready
  output logic [31:0]      s_axi_rdata_out,  // Read data
  output logic [1:0]       s_axi_rresp_out,  // Read response
  output logic             s_axi_rvalid_out, // Read data valid
  input  wire logic        s_axi_rready_in,  // Read data ready
  input  wire logic        rx_done_in,       // Frame received without error
  input  wire logic        rx_data_wr_in,    // Frame data written to receive FIFO
  input  wire logic        tx_done_in,       // Frame sent and status stored
  input  wire logic        tx_abort_in,      // Outgoing frame abandoned
  input  wire logic        rx_desc_ovr_in,   // Receive descriptor overrun
  input  wire logic        rx_fifo_ovf_in,   // Receive FIFO overflow
  input  wire logic [15:0] sa_factory_in,    // Factory station address octets 6,5
  input  wire logic        mdio_in,          // Management data pin, input side
  output logic             mdio_out,         // Management data pin, output side
  output logic             mdio_oe_out,      // Management data pin drive enable
  output logic             mdc_out,          // Management data clock
  output logic             irq_out           // Interrupt, level, active high
);

  localparam logic [5:0] MDC_LAST = 6'(`EIM_MDC_HALF_CYC - 1);

  eim_state_t q;
  eim_state_t d;

  logic       wr_go;
  logic [2:0] wr_grp;
  logic [1:0] wr_al;
  logic       wr_map;
  logic       wr_lo;
  logic       sw_dec;
  logic       mw_start;
  logic       rd_start;
  logic       mg_done;
  logic [7:0] flags_vis;
  logic [7:0] ev;

  // Alias arithmetic shared by every register but the control register
  function automatic logic [15:0] alias_op(input logic [1:0]  al,
                                           input logic [15:0] old,
                                           input logic [15:0] val);
    logic [15:0] r;
    r = val;
    unique case (al)
      `EIM_AL_PLAIN: r = val;
      `EIM_AL_SET:   r = old | val;
      `EIM_AL_CLEAR: r = old & ~val;
      `EIM_AL_FLIP:  r = old ^ val;
    endcase
    return r;
  endfunction : alias_op

  // Write decode from the held address and strobes
  assign wr_go  = q.aw_have && q.w_have && !q.bvalid;
  assign wr_grp = q.awaddr[6:4];
  assign wr_al  = q.awaddr[3:2];
  assign wr_map = (q.awaddr[7] == 1'b0) && (wr_grp <= `EIM_GRP_CTRL);
  assign wr_lo  = (q.wstrb == `EIM_STRB_ALL) || (q.wstrb == `EIM_STRB_LO);
  assign sw_dec = wr_go && wr_map && (wr_grp == `EIM_GRP_CTRL) && q.wstrb[0]
                  && q.wdata[`EIM_C_DEC] && (q.count != 8'h00);
  assign mw_start = wr_go && wr_map && (wr_grp == `EIM_GRP_MGWR) && wr_lo
                    && (q.mst == EIM_MG_IDLE);
  assign rd_start = wr_go && wr_map && (wr_grp == `EIM_GRP_CTRL) && q.wstrb[0]
                    && q.wdata[`EIM_C_RDGO] && (q.mst == EIM_MG_IDLE) && !mw_start;
  assign mg_done  = (q.mst == EIM_MG_RUN) && (q.div == MDC_LAST) && q.mdc
                    && (q.bitcnt == `EIM_FR_LAST);

  // Frame-waiting flag follows the pending count, never stored
  always_comb
  begin
    flags_vis = q.flags;
    flags_vis[`EIM_F_PEND] = (q.count != 8'h00);
  end

  // Hardware events in flag order
  always_comb
  begin
    ev = 8'h00;
    ev[`EIM_F_RXCMP]  = rx_done_in;
    ev[`EIM_F_RXSEEN] = rx_data_wr_in;
    ev[`EIM_F_TXCMP]  = tx_done_in;
    ev[`EIM_F_TXABRT] = tx_abort_in;
    ev[`EIM_F_RXDESC] = rx_desc_ovr_in;
    ev[`EIM_F_RXOVF]  = rx_fifo_ovf_in;
  end

  // Next-state logic for the whole block
  always_comb
  begin
    logic [15:0] rd_val;
    logic [15:0] tmp;
    rd_val = 16'h0000;
    tmp    = 16'h0000;
    d      = q;

    // Input synchroniser for the management data pin
    d.mdio_s1 = mdio_in;
    d.mdio_s2 = q.mdio_s1;

    // Write address and data capture, in either order
    if (s_axi_awvalid_in && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata_in;
      d.wstrb  = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in)
      d.bvalid = 1'b0;

    // Register writes through plain and alias offsets
    if (wr_go)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_map ? `EIM_RESP_OKAY : `EIM_RESP_SLVERR;
      if (wr_map)
      begin
        unique case (wr_grp)
          `EIM_GRP_IRQ:
            if (q.wstrb[0])
            begin
              tmp = alias_op(wr_al, {8'h00, q.flags}, {8'h00, q.wdata[7:0]});
              d.flags = tmp[7:0];
            end
          `EIM_GRP_MASK:
            if (q.wstrb[0])
            begin
              tmp = alias_op(wr_al, {8'h00, q.mask}, {8'h00, q.wdata[7:0]});
              d.mask = tmp[7:0];
            end
          `EIM_GRP_MGWR:
            if (wr_lo)
              d.mg_wdata = alias_op(wr_al, q.mg_wdata, q.wdata[15:0]);
          `EIM_GRP_MGRD:
            if (wr_lo)
              d.mg_rdata = alias_op(wr_al, q.mg_rdata, q.wdata[15:0]);
          `EIM_GRP_SA0:
            if (wr_lo)
              d.sa0 = alias_op(wr_al, q.sa0, q.wdata[15:0]);
          `EIM_GRP_MADR:
            if (wr_lo)
              d.madr = alias_op(wr_al, q.madr, q.wdata[15:0]);
          default: ;
        endcase
      end
    end

    // Hardware events win over a clear in the same cycle
    d.flags = d.flags | ev;
    d.flags[`EIM_F_PEND]   = 1'b0;
    d.flags[`EIM_F_UNUSED] = 1'b0;

    // Pending frame count: up on each frame, saturating at 255, down on software decrement
    if (rx_done_in && !sw_dec && (q.count != 8'hff))
      d.count = q.count + 8'h01;
    else if (sw_dec && !rx_done_in)
      d.count = q.count - 8'h01;

    // Read channel: one read in flight
    if (s_axi_arvalid_in && q.arready)
    begin
      unique case (s_axi_araddr_in[6:4])
        `EIM_GRP_IRQ:  rd_val = {8'h00, flags_vis};
        `EIM_GRP_MASK: rd_val = {8'h00, q.mask};
        `EIM_GRP_MGWR: rd_val = q.mg_wdata;
        `EIM_GRP_MGRD: rd_val = q.mg_rdata;
        `EIM_GRP_SA0:  rd_val = q.sa0;
        `EIM_GRP_MADR: rd_val = q.madr;
        `EIM_GRP_CTRL: rd_val = {q.count, 7'h00, (q.mst == EIM_MG_RUN)};
        default:       rd_val = 16'h0000;
      endcase
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = {16'h0000, rd_val};
      d.rresp   = (!s_axi_araddr_in[7] && (s_axi_araddr_in[6:4] <= `EIM_GRP_CTRL))
                  ? `EIM_RESP_OKAY : `EIM_RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready_in)
    begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // Management cycle start, write or read
    if (mw_start || rd_start)
    begin
      d.mst      = EIM_MG_RUN;
      d.div      = 6'h00;
      d.mdc      = 1'b0;
      d.bitcnt   = 7'h00;
      d.rd_op    = rd_start;
      d.tx       = {`EIM_PREAMBLE, `EIM_FR_START,
                    rd_start ? `EIM_OP_READ : `EIM_OP_WRITE,
                    q.madr[`EIM_MADR_PHY], q.madr[`EIM_MADR_REG],
                    rd_start ? `EIM_TA_READ : `EIM_TA_WRITE,
                    d.mg_wdata};
      d.mdio_oe  = 1'b1;
      d.mdio_out = 1'b1;
    end

    // Serial engine: drive on falling edge, sample on rising edge
    if (q.mst == EIM_MG_RUN)
    begin
      if (q.div == MDC_LAST)
      begin
        d.div = 6'h00;
        d.mdc = ~q.mdc;
        if (!q.mdc)
          d.rx = {q.rx[14:0], q.mdio_s2};
        else if (q.bitcnt == `EIM_FR_LAST)
        begin
          d.mst      = EIM_MG_IDLE;
          d.mdio_oe  = 1'b0;
          d.mdio_out = 1'b0;
          if (q.rd_op)
            d.mg_rdata = q.rx;
        end
        else
        begin
          d.tx       = {q.tx[62:0], 1'b0};
          d.bitcnt   = q.bitcnt + 7'h01;
          d.mdio_out = q.tx[62];
          d.mdio_oe  = !(q.rd_op && ((q.bitcnt + 7'h01) >= `EIM_TA_BIT));
        end
      end
      else
        d.div = q.div + 6'h01;
    end

    // Handshake readies and interrupt output
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.irq     = |({d.flags[7:1], d.flags[0]} & d.mask) || ((d.count != 8'h00) && d.mask[`EIM_F_PEND]);

    // Synchronous reset, station address from factory value
    if (!rstn_in)
    begin
      d          = '0;
      d.mst      = EIM_MG_IDLE;
      d.awready  = 1'b1;
      d.wready   = 1'b1;
      d.arready  = 1'b1;
      d.sa0      = sa_factory_in;
    end
  end

  // State register
  always_ff @(posedge mclk_in)
  begin
    q <= d;
  end

  // Outputs straight from the state register
  assign s_axi_awready_out = q.awready;
  assign s_axi_wready_out  = q.wready;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_arready_out = q.arready;
  assign s_axi_rdata_out   = q.rdata;
  assign s_axi_rresp_out   = q.rresp;
  assign s_axi_rvalid_out  = q.rvalid;
  assign mdio_out          = q.mdio_out;
  assign mdio_oe_out       = q.mdio_oe;
  assign mdc_out           = q.mdc;
  assign irq_out           = q.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_mw_req;
    mw_start;
  endsequence

  sequence s_run8;
    (q.mst == EIM_MG_RUN) [*8];
  endsequence

  a_rxcmp_set: assert property (rx_done_in |=> q.flags[`EIM_F_RXCMP])
    else $error("receive-complete flag not set");
  a_pend_track: assert property ((rx_done_in && !sw_dec && q.count == 8'h00)
    |=> flags_vis[`EIM_F_PEND] && q.count == 8'h01)
    else $error("frame-waiting flag does not follow count");
  a_rxseen_set: assert property (rx_data_wr_in |=> q.flags[`EIM_F_RXSEEN])
    else $error("receive-activity flag not set");
  a_tx_flags: assert property ((tx_done_in || tx_abort_in) |=>
    (!$past(tx_done_in) || q.flags[`EIM_F_TXCMP])
    && (!$past(tx_abort_in) || q.flags[`EIM_F_TXABRT]))
    else $error("transmit flag not set");
  a_rx_errs: assert property ((rx_desc_ovr_in || rx_fifo_ovf_in) |=>
    (!$past(rx_desc_ovr_in) || q.flags[`EIM_F_RXDESC])
    && (!$past(rx_fifo_ovf_in) || q.flags[`EIM_F_RXOVF]))
    else $error("receive error flag not set");
  a_flag_hold: assert property ($fell(q.flags[`EIM_F_RXCMP]) |->
    $past(wr_go && wr_map && wr_grp == `EIM_GRP_IRQ))
    else $error("flag cleared without register write");
  a_mw_start: assert property (s_mw_req |=> s_run8 ##0
    (q.tx[15:0] == $past(q.mg_wdata, 7) || q.rd_op)) // Word as stored by the start edge
    else $error("management write cycle did not start");
  a_rd_land: assert property ((mg_done && q.rd_op) |=> q.mg_rdata == $past(q.rx))
    else $error("management read data not stored");
  a_byte_ign: assert property ((wr_go && wr_map && wr_grp == `EIM_GRP_SA0 && !wr_lo)
    |=> q.sa0 == $past(q.sa0))
    else $error("8-bit access changed station address");
  a_upper_zero: assert property (q.rvalid |-> q.rdata[31:16] == 16'h0000)
    else $error("upper bits read nonzero");
  a_sa_reset: assert property ($rose(rstn_in) |-> q.sa0 == $past(sa_factory_in))
    else $error("station address not loaded at reset");
  a_busy_lock: assert property ((q.mst == EIM_MG_RUN && !mg_done) |=>
    q.mst == EIM_MG_RUN && q.rd_op == $past(q.rd_op))
    else $error("management cycle disturbed while busy");

endmodule : eim_top

// ==== pkg/eim_regs.svh ====
// Register offsets, field positions and timing counts for the
// Ethernet interrupt and management register slice; included by its bare name.
`ifndef EIM_REGS_SVH
`define EIM_REGS_SVH

// Address decode: bits 6:4 pick the register, bits 3:2 the alias
`define EIM_ADDR_W        8
`define EIM_GRP_IRQ       3'h0
`define EIM_GRP_MASK      3'h1
`define EIM_GRP_MGWR      3'h2
`define EIM_GRP_MGRD      3'h3
`define EIM_GRP_SA0       3'h4
`define EIM_GRP_MADR      3'h5
`define EIM_GRP_CTRL      3'h6
`define EIM_AL_PLAIN      2'h0
`define EIM_AL_SET        2'h1
`define EIM_AL_CLEAR      2'h2
`define EIM_AL_FLIP       2'h3

// Interrupt flag positions
`define EIM_F_RXCMP       7
`define EIM_F_PEND        6
`define EIM_F_RXSEEN      5
`define EIM_F_UNUSED      4
`define EIM_F_TXCMP       3
`define EIM_F_TXABRT      2
`define EIM_F_RXDESC      1
`define EIM_F_RXOVF       0

// Control register bits and address field layout
`define EIM_C_DEC         0
`define EIM_C_RDGO        1
`define EIM_S_BUSY        0
`define EIM_MADR_PHY      12:8
`define EIM_MADR_REG      4:0

// AXI responses
`define EIM_RESP_OKAY     2'h0
`define EIM_RESP_SLVERR   2'h2

// Byte-strobe patterns that make a 16-bit or 32-bit access
`define EIM_STRB_LO       4'h3
`define EIM_STRB_HI       4'hc
`define EIM_STRB_ALL      4'hf

// Management frame layout
`define EIM_PREAMBLE      32'hffffffff
`define EIM_FR_START      2'h1
`define EIM_OP_WRITE      2'h1
`define EIM_OP_READ       2'h2
`define EIM_TA_WRITE      2'h2
`define EIM_TA_READ       2'h0
`define EIM_FR_BITS       7'd64
`define EIM_FR_LAST       7'd63
`define EIM_TA_BIT        7'd46

// Timing: clock period and management clock half period, in ns
`define EIM_CLK_NS        10
`define EIM_MDC_HALF_NS   200
`define EIM_MDC_HALF_CYC  (`EIM_MDC_HALF_NS / `EIM_CLK_NS)

`endif

// ==== pkg/eim_pkg.sv ====
// Types shared by the Ethernet interrupt and management register slice.
// Assumes eim_regs.svh supplies the numeric constants.
package eim_pkg;

  typedef enum logic [1:0] {
    EIM_MG_IDLE = 2'b01,
    EIM_MG_RUN  = 2'b10
  } eim_mg_st_t;

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             aw_have;
    logic [7:0]       awaddr;
    logic             w_have;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [7:0]       flags;
    logic [7:0]       mask;
    logic [15:0]      mg_wdata;
    logic [15:0]      mg_rdata;
    logic [15:0]      sa0;
    logic [15:0]      madr;
    logic [7:0]       count;
    eim_mg_st_t       mst;
    logic [5:0]       div;
    logic             mdc;
    logic [6:0]       bitcnt;
    logic [63:0]      tx;
    logic [15:0]      rx;
    logic             rd_op;
    logic             mdio_oe;
    logic             mdio_out;
    logic             mdio_s1;
    logic             mdio_s2;
    logic             irq;
  } eim_state_t;

endpackage : eim_pkg

// ==== bench/eim_phy_model.sv ====
// Management-link PHY model: decodes frames on mdc, answers reads.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/100ps

module eim_phy_model (
  input  wire logic        mdc_in,    // Management clock from the block
  input  wire logic        line_in,   // Resolved data line level
  input  wire logic [15:0] rd_val_in, // Value returned on reads
  output logic             oe_out,    // High while the model drives
  output logic             dout_out,  // Bit driven on the line
  output logic [1:0]       op_out,    // Last frame opcode
  output logic [4:0]       phy_out,   // Last frame PHY address
  output logic [4:0]       reg_out,   // Last frame register address
  output logic [15:0]      data_out,  // Last frame data
  output int               frames_out // Frames seen so far
);
  logic [47:0] sh_q;
  logic [47:0] nv;
  logic        rd_q;
  int          k_q;

  initial
  begin
    {sh_q, nv, rd_q, k_q, oe_out, dout_out} = '0;
    {op_out, phy_out, reg_out, data_out, frames_out} = '0;
  end

  // Shift in bits, find the start pattern, record each whole frame
  always @(posedge mdc_in)
  begin
    nv = {sh_q[46:0], line_in};
    sh_q <= nv;
    if (k_q == 0)
    begin
      if (nv[1:0] == 2'h1 && (&nv[33:2])) k_q <= 1;
    end
    else if (k_q == 30)
    begin
      op_out     <= nv[29:28];
      phy_out    <= nv[27:23];
      reg_out    <= nv[22:18];
      data_out   <= nv[15:0];
      frames_out <= frames_out + 1;
      k_q        <= 0;
    end
    else
    begin
      if (k_q == 2) rd_q <= (nv[1:0] == 2'h2);
      k_q <= k_q + 1;
    end
  end

  // Read reply: second turnaround bit low, then data MSB first
  always @(negedge mdc_in)
  begin
    oe_out   <= rd_q && k_q >= 14;
    dout_out <= (k_q > 14) ? rd_val_in[30 - k_q] : 1'b0;
  end
endmodule : eim_phy_model

// ==== bench/eim_top_test.sv ====
// Self-checking bench for the interrupt, management and station registers.
// Assumes eim_top with the PHY model on a pulled-up management data line.
`timescale 1ns/100ps
`include "eim_regs.svh"

module eim_top_test;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, p_op, r;
  logic [5:0]  ev = 6'h00;
  logic [15:0] sa_fact = 16'ha55a, rd_val = 16'h5a3c, p_data;
  logic [4:0]  p_phy, p_reg;
  logic [7:0]  pend;
  logic [31:0] d;
  logic        mdio_o, mdio_oe, mdc, irq, phy_oe, phy_do;
  int          p_frames, err_total = 0, checked = 0;
  wire         mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_do : 1'b1);
  // Event pattern beside the flags it should raise
  localparam logic [13:0] row_tab [0:5] = '{{6'h20, 8'hc0}, {6'h10, 8'h20},
    {6'h08, 8'h08}, {6'h04, 8'h04}, {6'h02, 8'h02}, {6'h01, 8'h01}};

  always #5 mclk = ~mclk;

  eim_top eim_top_inst (.mclk_in(mclk), .rstn_in(rstn),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .rx_done_in(ev[5]),
    .rx_data_wr_in(ev[4]), .tx_done_in(ev[3]), .tx_abort_in(ev[2]),
    .rx_desc_ovr_in(ev[1]), .rx_fifo_ovf_in(ev[0]), .sa_factory_in(sa_fact),
    .mdio_in(mdio_line), .mdio_out(mdio_o), .mdio_oe_out(mdio_oe), .mdc_out(mdc),
    .irq_out(irq));

  eim_phy_model eim_phy_model_inst (.mdc_in(mdc), .line_in(mdio_line),
    .rd_val_in(rd_val), .oe_out(phy_oe), .dout_out(phy_do), .op_out(p_op),
    .phy_out(p_phy), .reg_out(p_reg), .data_out(p_data), .frames_out(p_frames));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Write cycle: both channels offered together, released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
    awaddr <= a;
    wdata  <= dt;
    wstrb  <= s;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
  endtask : axi_rd

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk(nm, e, d);
  endtask : rchk

  // One-cycle event strobe, then one edge so the flags have settled
  task automatic pulse(input logic [5:0] e);
    ev <= e;
    @(posedge mclk);
    ev <= 6'h00;
    @(posedge mclk);
  endtask : pulse

  // Poll the busy bit until the management cycle is over; the watchdog bounds it
  task automatic wait_idle;
    do
      axi_rd(8'h60);
    while (d[0] !== 1'b0);
  endtask : wait_idle

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Watchdog against a hung handshake
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk("irq rst", 32'h0, {31'h0, irq});
    rchk("flags rst", 8'h00, 32'h0);
    rchk("wdata rst", 8'h20, 32'h0);
    rchk("sa0 rst", 8'h40, {16'h0, sa_fact});
    axi_wr(8'h10, 32'hff, 4'hf);
    pend = 8'h00;
    // Each event sets its flag; clear alias removes all but frame-waiting
    foreach (row_tab[i])
    begin
      pulse(row_tab[i][13:8]);
      pend = pend | (row_tab[i][7:0] & 8'h40);
      rchk("flags set", 8'h00, {24'h0, row_tab[i][7:0] | pend});
      chk("irq set", 32'h1, {31'h0, irq});
      axi_wr(8'h08, {24'h0, row_tab[i][7:0]}, 4'hf);
      rchk("flags clr", 8'h00, {24'h0, pend});
      chk("irq clr", {31'h0, pend != 8'h00}, {31'h0, irq});
    end
    rchk("count", 8'h60, 32'h100);
    axi_wr(8'h00, 32'h0, 4'hf);
    rchk("pend write", 8'h00, 32'h40);
    axi_wr(8'h60, 32'h1, 4'hf);
    rchk("pend dec", 8'h00, 32'h0);
    axi_wr(8'h04, 32'h40, 4'hf);
    rchk("pend set", 8'h00, 32'h0);
    // Mask gates the interrupt; invert alias clears a flag
    axi_wr(8'h10, 32'h0, 4'hf);
    pulse(6'h04);
    chk("irq masked", 32'h0, {31'h0, irq});
    axi_wr(8'h14, 32'h4, 4'hf);
    chk("irq unmask", 32'h1, {31'h0, irq});
    axi_wr(8'h0c, 32'h4, 4'hf);
    rchk("flags inv", 8'h00, 32'h0);
    chk("irq inv", 32'h0, {31'h0, irq});
    // Station register widths and access sizes
    axi_wr(8'h40, 32'hffff1234, 4'hf);
    rchk("sa0 word", 8'h40, 32'h1234);
    axi_wr(8'h40, 32'h000000ff, 4'h1);
    rchk("sa0 byte", 8'h40, 32'h1234);
    axi_wr(8'h44, 32'h0000c000, 4'h3);
    rchk("sa0 half", 8'h40, 32'hd234);
    axi_wr(8'h70, 32'h1, 4'hf);
    chk("unmapped wr", {30'h0, `EIM_RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h70);
    chk("unmapped rd", {30'h0, `EIM_RESP_SLVERR}, {30'h0, r});
    // Management write, with a second start refused while busy
    axi_wr(8'h50, 32'h0a13, 4'hf);
    rchk("addr reg", 8'h50, 32'h0a13);
    axi_wr(8'h20, 32'hbeef, 4'hf);
    rchk("busy", 8'h60, 32'h1);
    axi_wr(8'h20, 32'h1111, 4'hf);
    rchk("wdata held", 8'h20, 32'h1111);
    wait_idle();
    chk("wr frames", 32'h1, p_frames);
    chk("wr frame", {`EIM_OP_WRITE, 14'h0a13, 16'hbeef},
        {p_op, 1'b0, p_phy, 3'h0, p_reg, p_data});
    repeat (3000) @(posedge mclk);
    chk("no restart", 32'h1, p_frames);
    // Management read returns the PHY value
    axi_wr(8'h60, 32'h2, 4'hf);
    wait_idle();
    chk("rd op", {30'h0, `EIM_OP_READ}, {30'h0, p_op});
    rchk("rdata word", 8'h30, {16'h0, rd_val});
    // Second reset reloads a changed factory address
    sa_fact <= 16'h3c96;
    rstn    <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rchk("sa0 rst2", 8'h40, 32'h3c96);
    rchk("rdata rst2", 8'h30, 32'h0);
    test_done();
  end
endmodule : eim_top_test
